// File: logic/oag_pkg.sv
package oag_pkg;

  // Addressing modes, one-hot
  typedef enum logic [11:0] {
    OAG_REG     = 12'h001,
    OAG_IMM     = 12'h002,
    OAG_DP      = 12'h004,
    OAG_ABS     = 12'h008,
    OAG_DPX     = 12'h010,
    OAG_DPXINC  = 12'h020,
    OAG_DPXOFF  = 12'h040,
    OAG_DPYOFF  = 12'h080,
    OAG_ABSY    = 12'h100,
    OAG_DPIND   = 12'h200,
    OAG_XIND    = 12'h400,
    OAG_YIND    = 12'h800
  } oag_mode_e;

  // Absolute indirect reuses the pointer path with a 16-bit base
  localparam logic [3:0] OAG_ABSIND_SEL = 4'hc;

  // Internal register selectors for register addressing
  typedef enum logic [2:0] {
    OAG_SEL_ACC = 3'h0,
    OAG_SEL_X   = 3'h1,
    OAG_SEL_Y   = 3'h2,
    OAG_SEL_C   = 3'h3,
    OAG_SEL_PSW = 3'h4
  } oag_regsel_e;

  localparam logic [7:0] OAG_DP_PAGE = 8'h00;
  localparam logic [15:0] OAG_ADDR_RST = 16'h0000;
  localparam logic [7:0] OAG_BYTE_RST = 8'h00;
  localparam logic [7:0] OAG_X_STEP = 8'h01;

  // Request from the decoder
  typedef struct packed {
    logic absInd;       // Absolute indirect, jump only
    oag_mode_e mode;
    oag_regsel_e regSel;
    logic [7:0] opLo;   // Second instruction byte
    logic [7:0] opHi;   // Third instruction byte
  } oag_req_s;

  // Result to the core
  typedef struct packed {
    logic isReg;
    logic isImm;
    oag_regsel_e regSel;
    logic [7:0] immData;
    logic [15:0] addr;
  } oag_res_s;

endpackage

// File: logic/oag_operand_address_generator.sv
`timescale 1ns/100ps
module oag_operand_address_generator (
  input wire logic clk_sys,          // System clock
  input wire logic rstn,             // Async reset, active low
  input wire logic reqValid,         // Start one address generation
  input wire oag_pkg::oag_req_s req, // Mode and operand bytes
  input wire logic [7:0] xIdx,       // X index register
  input wire logic [7:0] yIdx,       // Y index register
  input wire logic [7:0] memRdata,   // Data memory read byte
  output logic memRd_ff,             // Pointer byte read strobe
  output logic [15:0] memAddr_ff,    // Pointer byte address
  output logic xIncr_ff,             // Pulse: core adds one to X
  output logic done_ff,              // Pulse: result valid
  output logic busy_ff,              // Request in progress
  output oag_pkg::oag_res_s res_ff   // Operand location
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_LO   = 4'h2,
    ST_HI   = 4'h4,
    ST_DONE = 4'h8
  } oag_st_e;

  oag_st_e st_ff;
  oag_st_e nxt_st;
  logic [7:0] ptrLo_ff;
  logic [7:0] yHold_ff;
  logic ptrMode_ff;
  logic absPtr_ff;
  logic needPtr;
  logic [15:0] ptrBase;
  logic [15:0] nxt_addr;
  oag_pkg::oag_res_s nxt_res;

  // Direct mode decode; pointer modes only pick a base here
  always_comb begin
    nxt_res = '0;
    nxt_res.regSel = req.regSel;
    nxt_addr = oag_pkg::OAG_ADDR_RST;
    needPtr = 1'b0;
    ptrBase = oag_pkg::OAG_ADDR_RST;
    if (req.absInd) begin
      needPtr = 1'b1;
      ptrBase = {req.opHi, req.opLo};
    end else begin
      unique case (req.mode)
        oag_pkg::OAG_REG: nxt_res.isReg = 1'b1;
        oag_pkg::OAG_IMM: begin
          nxt_res.isImm = 1'b1;
          nxt_res.immData = req.opLo;
        end
        oag_pkg::OAG_DP: nxt_addr = {oag_pkg::OAG_DP_PAGE, req.opLo};
        oag_pkg::OAG_ABS: nxt_addr = {req.opHi, req.opLo};
        oag_pkg::OAG_DPX: nxt_addr = {oag_pkg::OAG_DP_PAGE, xIdx};
        oag_pkg::OAG_DPXINC: nxt_addr = {oag_pkg::OAG_DP_PAGE, xIdx};
        // 8-bit sum drops its carry so the page never changes
        oag_pkg::OAG_DPXOFF: nxt_addr = {oag_pkg::OAG_DP_PAGE, 8'(req.opLo + xIdx)};
        oag_pkg::OAG_DPYOFF: nxt_addr = {oag_pkg::OAG_DP_PAGE, 8'(req.opLo + yIdx)};
        oag_pkg::OAG_ABSY: nxt_addr = 16'({req.opHi, req.opLo} + {8'h00, yIdx});
        oag_pkg::OAG_DPIND: begin
          needPtr = 1'b1;
          ptrBase = {oag_pkg::OAG_DP_PAGE, req.opLo};
        end
        oag_pkg::OAG_XIND: begin
          needPtr = 1'b1;
          ptrBase = {oag_pkg::OAG_DP_PAGE, 8'(req.opLo + xIdx)};
        end
        oag_pkg::OAG_YIND: begin
          needPtr = 1'b1;
          ptrBase = {oag_pkg::OAG_DP_PAGE, req.opLo};
        end
        default: nxt_res.isReg = 1'b0;
      endcase
    end
    nxt_res.addr = nxt_addr;
  end

  // Sequencer: direct modes finish in two cycles, pointer modes read two bytes
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      ST_IDLE: if (reqValid) nxt_st = needPtr ? ST_LO : ST_DONE;
      ST_LO: nxt_st = ST_HI;
      ST_HI: nxt_st = ST_DONE;
      ST_DONE: nxt_st = ST_IDLE;
      default: nxt_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_ff <= ST_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Pointer fetch address; memory answers one cycle after the strobe
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      memRd_ff <= 1'b0;
      memAddr_ff <= oag_pkg::OAG_ADDR_RST;
    end else if (st_ff == ST_IDLE && reqValid && needPtr) begin
      memRd_ff <= 1'b1;
      memAddr_ff <= ptrBase; // Low byte first
    end else if (st_ff == ST_LO) begin
      memRd_ff <= 1'b1;
      // Page pointers wrap in the page; the absolute one carries, even from page zero
      if (absPtr_ff) begin
        memAddr_ff <= 16'(memAddr_ff + 16'h0001);
      end else begin
        memAddr_ff <= {memAddr_ff[15:8], 8'(memAddr_ff[7:0] + 8'h01)};
      end
    end else begin
      memRd_ff <= 1'b0;
    end
  end

  // Capture low pointer byte, Y for the Y-indirect sum and the pointer kind
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ptrLo_ff <= oag_pkg::OAG_BYTE_RST;
      yHold_ff <= oag_pkg::OAG_BYTE_RST;
      ptrMode_ff <= 1'b0;
      absPtr_ff <= 1'b0;
    end else begin
      if (st_ff == ST_IDLE && reqValid) begin
        yHold_ff <= (req.mode == oag_pkg::OAG_YIND && !req.absInd) ? yIdx : 8'h00;
        ptrMode_ff <= needPtr;
        absPtr_ff <= req.absInd;
      end
      if (st_ff == ST_HI) begin
        // Low byte is on the read bus the cycle after its strobe
        ptrLo_ff <= memRdata;
      end
    end
  end

  // Result and handshake outputs
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      res_ff <= '0;
      done_ff <= 1'b0;
      busy_ff <= 1'b0;
      xIncr_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      xIncr_ff <= 1'b0;
      if (st_ff == ST_IDLE && reqValid) begin
        busy_ff <= 1'b1;
        res_ff <= nxt_res;
        // Post-increment only after the access used the old X
        xIncr_ff <= !req.absInd && req.mode == oag_pkg::OAG_DPXINC;
      end
      if (st_ff == ST_DONE) begin
        done_ff <= 1'b1;
        busy_ff <= 1'b0;
        // High byte only reaches the read bus now; Y adds after the pair
        if (ptrMode_ff) begin
          res_ff.addr <= 16'({memRdata, ptrLo_ff} + {8'h00, yHold_ff});
        end
      end
    end
  end

  // Two strobes, low then high pointer byte, then the strobe drops
  sequence s_ptr_fetch;
    memRd_ff ##1 memRd_ff ##1 !memRd_ff;
  endsequence

  property p_ptr_two_reads;
    @(posedge clk_sys) disable iff (!rstn)
      (st_ff == ST_IDLE && reqValid && needPtr) |=> s_ptr_fetch;
  endproperty
  chk_ptr_reads: assert property (p_ptr_two_reads) else $error("pointer reads wrong");

  chk_direct_done: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_ff == ST_IDLE && reqValid && !needPtr) |-> ##2 done_ff) else $error("direct late");

  chk_ptr_done: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_ff == ST_IDLE && reqValid && needPtr) |-> ##4 done_ff) else $error("pointer late");

  chk_dp_page: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_ff == ST_IDLE && reqValid && !req.absInd && req.mode == oag_pkg::OAG_DPXOFF)
    |=> res_ff.addr == {8'h00, 8'($past(req.opLo) + $past(xIdx))}) else $error("dp+x wrong");

  chk_abs_y: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_ff == ST_IDLE && reqValid && !req.absInd && req.mode == oag_pkg::OAG_ABSY)
    |=> res_ff.addr == 16'({$past(req.opHi), $past(req.opLo)} + {8'h00, $past(yIdx)}))
    else $error("abs+y wrong");

  chk_imm_data: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_ff == ST_IDLE && reqValid && !req.absInd && req.mode == oag_pkg::OAG_IMM)
    |=> res_ff.isImm && res_ff.immData == $past(req.opLo) && !memRd_ff)
    else $error("immediate wrong");

  chk_x_incr: assert property (@(posedge clk_sys) disable iff (!rstn)
    xIncr_ff |-> $past(req.mode) == oag_pkg::OAG_DPXINC && !$past(req.absInd) && busy_ff)
    else $error("bad x inc");

  chk_reg_mode: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_ff == ST_IDLE && reqValid && !req.absInd && req.mode == oag_pkg::OAG_REG)
    |=> res_ff.isReg && res_ff.regSel == $past(req.regSel)) else $error("register wrong");

  chk_pair_page: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_ff == ST_HI && !absPtr_ff) |-> memAddr_ff[15:8] == oag_pkg::OAG_DP_PAGE)
    else $error("pointer pair left page");

  chk_done_pulse: assert property (@(posedge clk_sys) disable iff (!rstn)
    done_ff |-> !busy_ff ##1 !done_ff) else $error("done not a pulse");

endmodule

// File: testbench/oag_mem_model.sv
`timescale 1ns/100ps
module oag_mem_model (
  input wire logic clk_sys, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic memRd, // Read strobe
  input wire logic [15:0] memAddr, // Byte address
  output logic [7:0] memRdata // Read byte
);
  // Byte follows address; idle bus toggles so a stale byte is never taken
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      memRdata <= 8'h00;
    end else if (memRd) begin
      memRdata <= memAddr[7:0] ^ {memAddr[11:8], memAddr[15:12]} ^ 8'h5a;
    end else begin
      memRdata <= ~memRdata;
    end
  end
endmodule

// File: testbench/operand_address_generator_test.sv
`timescale 1ns/100ps
module operand_address_generator_test;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic reqValid = 1'b0;
  oag_pkg::oag_req_s req = '0;
  logic [7:0] xIdx = 8'h00;
  logic [7:0] yIdx = 8'h00;
  logic [7:0] memRdata;
  logic memRd_ff, xIncr_ff, done_ff, busy_ff;
  logic [15:0] memAddr_ff;
  oag_pkg::oag_res_s res_ff;
  int mismatches = 0;
  int total_checks = 0;

  oag_operand_address_generator i_dut (.clk_sys(clk_sys), .rstn(rstn), .reqValid(reqValid),
    .req(req), .xIdx(xIdx), .yIdx(yIdx), .memRdata(memRdata), .memRd_ff(memRd_ff),
    .memAddr_ff(memAddr_ff), .xIncr_ff(xIncr_ff), .done_ff(done_ff), .busy_ff(busy_ff),
    .res_ff(res_ff));
  oag_mem_model i_mem (.clk_sys(clk_sys), .rstn(rstn), .memRd(memRd_ff),
    .memAddr(memAddr_ff), .memRdata(memRdata));

  // 20 MHz system clock
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  // Own copy of the memory pattern, kept apart from the model
  function automatic logic [15:0] ptr(input logic [15:0] a0, input logic [15:0] a1);
    ptr = {a1[7:0] ^ {a1[11:8], a1[15:12]} ^ 8'h5a, a0[7:0] ^ {a0[11:8], a0[15:12]} ^ 8'h5a};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One request, then latency, side pulses and address; returns on the done cycle
  task automatic runOp(input oag_pkg::oag_mode_e md, input logic ind, input logic [2:0] sel,
    input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] x, input logic [7:0] y,
    input logic [15:0] expAddr, input int lat);
    int n;
    logic sawInc, sawRd, sawBusy;
    sawInc = 1'b0;
    sawRd = 1'b0;
    sawBusy = 1'b0;
    req = '{ind, md, oag_pkg::oag_regsel_e'(sel), lo, hi};
    xIdx = x;
    yIdx = y;
    reqValid = 1'b1;
    @(negedge clk_sys);
    reqValid = 1'b0;
    for (n = 1; n < 8 && done_ff !== 1'b1; n++) begin
      sawInc = sawInc | (xIncr_ff === 1'b1);
      sawRd = sawRd | (memRd_ff === 1'b1);
      sawBusy = sawBusy | (busy_ff === 1'b1);
      @(negedge clk_sys);
    end
    chk(n, lat);
    chk(res_ff.addr, expAddr);
    chk(sawInc, md == oag_pkg::OAG_DPXINC && !ind);
    chk(sawRd, lat == 4);
    chk(sawBusy, 1'b1);
    chk(busy_ff, 1'b0);
  endtask

  // Register and immediate operands
  task automatic scnDirect();
    for (int s = 0; s < 5; s++) begin
      runOp(oag_pkg::OAG_REG, 1'b0, s[2:0], 8'h77, 8'h00, 8'h00, 8'h00, 16'h0000, 2);
      chk(res_ff.isReg, 1'b1);
      chk(res_ff.regSel, s[2:0]);
    end
    runOp(oag_pkg::OAG_IMM, 1'b0, 3'h0, 8'h35, 8'h00, 8'h00, 8'h00, 16'h0000, 2);
    chk({res_ff.isImm, res_ff.immData}, 9'h135);
  endtask

  // Page, absolute and indexed forms, with wrap and carry edges
  task automatic scnIndexed();
    runOp(oag_pkg::OAG_DP, 1'b0, 3'h0, 8'h35, 8'h00, 8'h00, 8'h00, 16'h0035, 2);
    runOp(oag_pkg::OAG_ABS, 1'b0, 3'h0, 8'h35, 8'hf0, 8'h00, 8'h00, 16'hf035, 2);
    runOp(oag_pkg::OAG_DPX, 1'b0, 3'h0, 8'h99, 8'h00, 8'h15, 8'h00, 16'h0015, 2);
    runOp(oag_pkg::OAG_DPXINC, 1'b0, 3'h0, 8'h00, 8'h00, 8'h35, 8'h00, 16'h0035, 2);
    runOp(oag_pkg::OAG_DPXOFF, 1'b0, 3'h0, 8'hf0, 8'h00, 8'h20, 8'h00, 16'h0010, 2);
    runOp(oag_pkg::OAG_DPYOFF, 1'b0, 3'h0, 8'hf0, 8'h00, 8'h00, 8'h21, 16'h0011, 2);
    runOp(oag_pkg::OAG_ABSY, 1'b0, 3'h0, 8'hff, 8'h12, 8'h00, 8'h01, 16'h1300, 2);
  endtask

  // Pointer fetches, all pairs but the first crossing the page end
  task automatic scnPointer();
    runOp(oag_pkg::OAG_DPIND, 1'b0, 3'h0, 8'h35, 8'h00, 8'h00, 8'h00,
      ptr(16'h0035, 16'h0036), 4);
    runOp(oag_pkg::OAG_XIND, 1'b0, 3'h0, 8'hf5, 8'h00, 8'h0a, 8'h00,
      ptr(16'h00ff, 16'h0000), 4);
    runOp(oag_pkg::OAG_YIND, 1'b0, 3'h0, 8'hff, 8'h00, 8'h00, 8'h10,
      ptr(16'h00ff, 16'h0000) + 16'h0010, 4);
    runOp(oag_pkg::OAG_ABS, 1'b1, 3'h0, 8'hff, 8'hc0, 8'h00, 8'h00,
      ptr(16'hc0ff, 16'hc100), 4);
    runOp(oag_pkg::OAG_ABS, 1'b1, 3'h0, 8'hff, 8'h00, 8'h00, 8'h00,
      ptr(16'h00ff, 16'h0100), 4);
  endtask

  task automatic tally_and_finish();
    if (mismatches == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Main sequence, requests back to back on each done cycle
  initial begin
    repeat (20) @(negedge clk_sys);
    rstn = 1'b1;
    chk({done_ff, busy_ff, memRd_ff}, 3'h0);
    scnDirect();
    scnIndexed();
    scnPointer();
    tally_and_finish();
  end

  // Hang guard, well past the roughly 66 cycles of reset and traffic
  initial begin
    #200000;
    mismatches++;
    tally_and_finish();
  end
endmodule
